// ---- rtl/reload_timer.sv ----
// Reloadable 16-bit timer with AXI4-Lite register access
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "timer_params.svh"
// Operation
// - Counter is 16 bits and increments by one per qualified tick.
// - Clock modes divide system clock by prescale 1 to 128.
// - Count at FFFFH without reload match wraps to 0000H and continues.
// - Reload 0000H gives full wrap; 0001H with prescale 1 is shortest.
// - One-shot reload match interrupts, loads 0001H, clears enable.
// - One-shot with output on inverts output pin one cycle.
// - One-shot and continuous ticks come from prescaled clock only.
// - Continuous and counter reload match interrupts, loads 0001H, runs on.
// - Continuous and counter modes toggle output on each reload.
// - Start count applies to first pass; reloads restart at 0001H.
// - Counter mode counts input edges chosen by polarity bit.
// - Counter mode bypasses prescaler; one edge, one count.
// - Counter mode polarity sets initial output level.
module reload_timer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        timer_in,
  output logic             timer_out,
  output logic             timer_out_en,
  output logic             irq
);
  import timer_pkg::*;

  // ****************************************************
  // Registers and state
  // ****************************************************
  logic        enable;
  timer_mode_t mode;
  logic [2:0]  prescale_sel;
  logic        output_polarity_edge_select;
  logic        out_func_en;
  logic [15:0] count;
  logic [15:0] reload;
  logic        status;
  logic        mask;
  logic        out_level;
  logic        in_meta;
  logic        in_sync;
  logic        in_prev;

  // ****************************************************
  // AXI4-Lite write channel
  // ****************************************************
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_rresp   = 2'h0;

  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire have_aw  = aw_held || aw_take;
  wire have_w   = w_held || w_take;
  wire wr_fire  = have_aw && have_w && !s_axi_bvalid;
  wire [7:0]  wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;

  wire wr_ctrl   = wr_fire && wr_addr == `OFF_CTRL && wr_strb[0];
  wire wr_cnt_lo = wr_fire && wr_addr == `OFF_COUNT && wr_strb[0];
  wire wr_cnt_hi = wr_fire && wr_addr == `OFF_COUNT && wr_strb[1];
  wire wr_rl_lo  = wr_fire && wr_addr == `OFF_RELOAD && wr_strb[0];
  wire wr_rl_hi  = wr_fire && wr_addr == `OFF_RELOAD && wr_strb[1];
  wire wr_stat   = wr_fire && wr_addr == `OFF_STATUS && wr_strb[0];
  wire wr_mask   = wr_fire && wr_addr == `OFF_MASK && wr_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_take && !wr_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (w_take && !wr_fire) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      s_axi_bvalid <= 1'b0;
    else if (wr_fire)
      s_axi_bvalid <= 1'b1;
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ****************************************************
  // AXI4-Lite read channel
  // ****************************************************
  assign s_axi_arready = !s_axi_rvalid;
  wire rd_take = s_axi_arvalid && s_axi_arready;

  wire [31:0] ctrl_word = {24'h00_0000, out_func_en,
                           output_polarity_edge_select,
                           prescale_sel, mode, enable};
  wire [31:0] rd_word =
    (s_axi_araddr == `OFF_CTRL)   ? ctrl_word :
    (s_axi_araddr == `OFF_COUNT)  ? {16'h0000, count} :
    (s_axi_araddr == `OFF_RELOAD) ? {16'h0000, reload} :
    (s_axi_araddr == `OFF_STATUS) ? {31'h0000_0000, status} :
    (s_axi_araddr == `OFF_MASK)   ? {31'h0000_0000, mask} :
                                    32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************
  // Tick sources
  // ****************************************************
  logic clk_tick;
  wire  clock_mode = (mode == MODE_ONE_SHOT) || (mode == MODE_CONTINUOUS);

  tick_prescaler #(.SEL_W(3)) u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (enable && clock_mode),
    .sel     (prescale_sel),
    .tick    (clk_tick)
  );

  // Two-stage synchroniser, then a registered edge compare
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_meta <= 1'b0;
      in_sync <= 1'b0;
      in_prev <= 1'b0;
    end else begin
      in_meta <= timer_in;
      in_sync <= in_meta;
      in_prev <= in_sync;
    end
  end

  wire rise     = in_sync && !in_prev;
  wire fall     = !in_sync && in_prev;
  wire pin_edge = output_polarity_edge_select ? rise : fall;

  // Pin edges count only in counter mode, unscaled
  wire tick = enable &&
              (clock_mode ? clk_tick :
               (mode == MODE_COUNTER) && pin_edge);

  // ****************************************************
  // Counter and reload
  // ****************************************************
  wire        match      = tick && (count == reload);
  wire [15:0] next_count = match ? `COUNT_RESTART
                                 : count + 16'h0001;
  wire        oneshot_end = match && (mode == MODE_ONE_SHOT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count  <= `COUNT_RESET;
      reload <= `RELOAD_RESET;
    end else begin
      if (tick)
        count <= next_count;
      else begin
        if (wr_cnt_lo)
          count[7:0] <= wr_data[7:0];
        if (wr_cnt_hi)
          count[15:8] <= wr_data[15:8];
      end
      if (wr_rl_lo)
        reload[7:0] <= wr_data[7:0];
      if (wr_rl_hi)
        reload[15:8] <= wr_data[15:8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable                      <= 1'b0;
      mode                        <= MODE_ONE_SHOT;
      prescale_sel                <= 3'h0;
      output_polarity_edge_select <= 1'b0;
      out_func_en                 <= 1'b0;
    end else if (oneshot_end) begin
      enable <= 1'b0;
    end else if (wr_ctrl) begin
      enable       <= wr_data[`CTRL_EN_BIT];
      mode         <= timer_mode_t'(wr_data[`CTRL_MODE_LSB +: 2]);
      prescale_sel <= wr_data[`CTRL_PRE_LSB +: 3];
      output_polarity_edge_select <= wr_data[`CTRL_POL_BIT];
      out_func_en  <= wr_data[`CTRL_OUTE_BIT];
    end
  end

  // ****************************************************
  // Timer output
  // ****************************************************
  // While disabled the level follows the polarity bit
  // A match toggles the level in every mode; a one-shot stop reloads the
  // polarity next cycle, so a polarity flipped mid-run keeps the new level
  always_ff @(posedge aclk) begin
    if (!aresetn)
      out_level <= 1'b0;
    else if (!enable)
      out_level <= output_polarity_edge_select;
    else if (match)
      out_level <= !out_level;
  end

  assign timer_out    = out_level;
  assign timer_out_en = out_func_en;

  // ****************************************************
  // Interrupt
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= 1'b0;
      mask   <= 1'b0;
    end else begin
      if (match)
        status <= 1'b1;
      else if (wr_stat && wr_data[`STAT_RELOAD])
        status <= 1'b0;
      if (wr_mask)
        mask <= wr_data[`STAT_RELOAD];
    end
  end

  assign irq = status && mask;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reload_restart_a: assert property (match |=> count == 16'h0001)
    else $error("count did not restart at one");
  oneshot_stop_a: assert property (oneshot_end |=> !enable)
    else $error("one-shot did not disable");
  cont_runs_a: assert property (
    match && mode != MODE_ONE_SHOT && !wr_ctrl |=> enable)
    else $error("continuous mode stopped");
  wrap_a: assert property (
    tick && count == 16'hFFFF && reload != 16'hFFFF |=> count == 16'h0000)
    else $error("count did not wrap");
  inc_a: assert property (
    tick && !match |=> count == $past(count) + 16'h0001)
    else $error("count did not step by one");
  pulse_one_a: assert property (
    oneshot_end ##1 !wr_ctrl
    |-> timer_out != $past(timer_out) ##1
        timer_out == output_polarity_edge_select)
    else $error("one-shot pulse not one cycle");
  toggle_a: assert property (
    enable && match && mode != MODE_ONE_SHOT |=> out_level != $past(out_level))
    else $error("output did not toggle");
  no_pin_a: assert property (
    clock_mode && !clk_tick |-> !tick)
    else $error("tick outside prescaler in clock mode");
  one_per_edge_a: assert property (
    mode == MODE_COUNTER && tick |=> !tick)
    else $error("two counts for one edge");
  irq_set_a: assert property (match |=> status)
    else $error("status not set on reload");

  // Count and status hold, tick sources and level checks
  hold_idle_a: assert property (
    !tick && !wr_cnt_lo && !wr_cnt_hi |=> count == $past(count))
    else $error("count moved without a tick");
  oneshot_halt_a: assert property (
    oneshot_end ##1 !wr_ctrl |-> !tick)
    else $error("one-shot kept counting");
  idle_level_a: assert property (
    !enable |=> out_level == $past(output_polarity_edge_select))
    else $error("idle level not polarity");
  edge_bypass_a: assert property (
    enable && mode == MODE_COUNTER && pin_edge |-> tick)
    else $error("pin edge not counted");
  edge_select_a: assert property (
    enable && mode == MODE_COUNTER && tick
    |-> (output_polarity_edge_select ? rise : fall))
    else $error("counted the wrong edge");
  presc_gap_a: assert property (
    clk_tick && prescale_sel != 3'h0 && !wr_ctrl |=> !clk_tick)
    else $error("prescaled ticks too close");
  presc_feed_a: assert property (
    clock_mode && enable && clk_tick |-> tick)
    else $error("prescaled tick lost");
  status_sticky_a: assert property (
    status && !(wr_stat && wr_data[`STAT_RELOAD]) |=> status)
    else $error("status lost without clear");
  cover_hold: cover property (
    oneshot_end && out_level != output_polarity_edge_select);
  cover_oneshot: cover property (oneshot_end);
  cover_cont: cover property (match && mode == MODE_CONTINUOUS);
  cover_counter: cover property (match && mode == MODE_COUNTER);
  cover_irq: cover property (irq);
endmodule

// ---- rtl/tick_prescaler.sv ----
// Clock divider producing a one-cycle tick every 2**sel cycles
`timescale 1ns/1ps
module tick_prescaler #(
  parameter int SEL_W = 3
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             run,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  tick
);
  localparam int CW = (1 << SEL_W) - 1;
  logic [CW-1:0] count;
  wire  [CW-1:0] limit = CW'((1 << sel) - 1);
  wire           hit   = (count >= limit);

  assign tick = run && hit;

  always_ff @(posedge aclk) begin
    if (!aresetn || !run || hit)
      count <= '0;
    else
      count <= count + CW'(1);
  end
endmodule

// ---- rtl/timer_params.svh ----
// Register offsets, field positions, reset values and timing constants
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH
`define OFF_CTRL      8'h00
`define OFF_COUNT     8'h04
`define OFF_RELOAD    8'h08
`define OFF_STATUS    8'h0C
`define OFF_MASK      8'h10
`define CTRL_EN_BIT   0
`define CTRL_MODE_LSB 1
`define CTRL_PRE_LSB  3
`define CTRL_POL_BIT  6
`define CTRL_OUTE_BIT 7
`define CTRL_RESET    32'h0000_0000
`define COUNT_RESET   16'h0000
`define RELOAD_RESET  16'h0000
`define COUNT_RESTART 16'h0001
`define PRESCALE_MAX  128
`define STAT_RELOAD   0
`endif

// ---- rtl/timer_pkg.sv ----
// Types shared by the timer files
package timer_pkg;
  typedef enum logic [1:0] {
    MODE_ONE_SHOT   = 2'h0,
    MODE_CONTINUOUS = 2'h1,
    MODE_COUNTER    = 2'h2,
    MODE_RESERVED   = 2'h3
  } timer_mode_t;
endpackage

// ---- test/gpio_pin_model.sv ----
// Pin source model driving the timer input through its alternate function
`timescale 1ns/1ps
module gpio_pin_model (
  input  wire logic aclk,
  output logic      timer_in
);
  initial timer_in = 1'b0;
  // ****************
  // Edge generator
  // ****************
  // High and low for 4 cycles each, well under a quarter of aclk
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge aclk);
      timer_in <= 1'b1;
      repeat (4) @(posedge aclk);
      timer_in <= 1'b0;
    end
  endtask
endmodule

// ---- test/reload_timer_tb.sv ----
// Self-checking bench for the reloadable timer
`timescale 1ns/1ps
`include "timer_params.svh"
module reload_timer_tb;
  import timer_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, d;
  logic        timer_in, timer_out, timer_out_en, irq;
  logic        prev_out = 1'b0;
  int          err_count = 0, n_compared = 0, i, h0;
  int          cyc = 0, last = 0, gap = 0, ntog = 0, hi_cnt = 0;

  reload_timer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_in, .timer_out,
    .timer_out_en, .irq);
  gpio_pin_model PIN (.aclk(aclk), .timer_in(timer_in));

  always #4 aclk = ~aclk;

  // ****************
  // Output pin monitor
  // ****************
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    prev_out <= timer_out;
    if (timer_out === 1'b1) hi_cnt <= hi_cnt + 1;
    if (timer_out !== prev_out) begin
      ntog <= ntog + 1;
      gap <= cyc - last;
      last <= cyc;
    end
  end

  // ****************
  // Bus and check tasks
  // ****************
  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tmo;
    err_count++;
    $display("wrong value wait expected 1 seen 0");
    summarize();
  endtask

  task automatic chk(input string s, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", 32'h0, s_axi_bresp);
    if (k == 64) tmo();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    chk("rresp", 32'h0, s_axi_rresp);
    s_axi_rready <= 1'b0;
    if (k == 64) tmo();
  endtask

  function automatic logic [31:0] ctl(input logic en, input timer_mode_t m,
                                      input logic [2:0] p, input logic pl, oe);
    ctl = 32'h0000_0000;
    ctl[`CTRL_EN_BIT] = en;
    ctl[`CTRL_MODE_LSB +: 2] = m;
    ctl[`CTRL_PRE_LSB +: 3] = p;
    ctl[`CTRL_POL_BIT] = pl;
    ctl[`CTRL_OUTE_BIT] = oe;
  endfunction

  task automatic cont(input logic [2:0] p, input logic [31:0] st, rl,
                      input int e);
    int b, k;
    wr(`OFF_CTRL, ctl(0, MODE_CONTINUOUS, p, 0, 1));
    wr(`OFF_COUNT, st);
    wr(`OFF_RELOAD, rl);
    b = ntog;
    wr(`OFF_CTRL, ctl(1, MODE_CONTINUOUS, p, 0, 1));
    fork PIN.pulses(3); join_none
    for (k = 0; k < 70000 && ntog < b + 2; k++) @(posedge aclk);
    if (k == 70000) tmo();
    chk("period", e, gap);
    wr(`OFF_CTRL, ctl(0, MODE_CONTINUOUS, p, 0, 1));
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    wr(8'h14, 32'hFFFF_FFFF);
    for (i = 0; i < 6; i++) begin
      rd(8'(i * 4), d);
      chk("reset value", 32'h0000_0000, d);
    end
    wr(`OFF_CTRL, ctl(0, MODE_ONE_SHOT, 0, 0, 1));
    wr(`OFF_COUNT, 32'h0000_0001);
    wr(`OFF_RELOAD, 32'h0000_0005);
    wr(`OFF_MASK, 32'h0000_0001);
    h0 = hi_cnt;
    wr(`OFF_CTRL, ctl(1, MODE_ONE_SHOT, 0, 0, 1));
    for (i = 0; i < 100 && irq !== 1'b1; i++) @(posedge aclk);
    if (i == 100) tmo();
    repeat (4) @(posedge aclk);
    chk("pulse cycles", h0 + 1, hi_cnt);
    chk("out enable", 32'h1, timer_out_en);
    rd(`OFF_CTRL, d);
    chk("ctrl", ctl(0, MODE_ONE_SHOT, 0, 0, 1), d);
    rd(`OFF_COUNT, d);
    chk("count", 32'h0000_0001, d);
    wr(`OFF_MASK, 32'h0000_0000);
    chk("irq masked", 32'h0, irq);
    rd(`OFF_STATUS, d);
    chk("status", 32'h0000_0001, d);
    wr(`OFF_STATUS, 32'h0000_0001);
    wr(`OFF_MASK, 32'h0000_0001);
    chk("irq cleared", 32'h0, irq);
    wr(`OFF_CTRL, ctl(0, MODE_ONE_SHOT, 0, 0, 1));
    wr(`OFF_COUNT, 32'h0000_0001);
    wr(`OFF_RELOAD, 32'h0000_0030);
    wr(`OFF_CTRL, ctl(1, MODE_ONE_SHOT, 0, 0, 1));
    wr(`OFF_CTRL, ctl(1, MODE_ONE_SHOT, 0, 1, 1));
    chk("level before", 32'h0, timer_out);
    for (i = 0; i < 100 && irq !== 1'b1; i++) @(posedge aclk);
    if (i == 100) tmo();
    repeat (4) @(posedge aclk);
    chk("level after", 32'h1, timer_out);
    wr(`OFF_STATUS, 32'h0000_0001);
    cont(3'h2, 32'h0000_FFFE, 32'h0000_0003, 12);
    cont(3'h7, 32'h0000_0001, 32'h0000_0002, 256);
    cont(3'h0, 32'h0000_FFFD, 32'h0000_0000, 65536);
    wr(`OFF_CTRL, ctl(0, MODE_COUNTER, 0, 1, 0));
    repeat (2) @(posedge aclk);
    chk("start level", 32'h1, timer_out);
    wr(`OFF_COUNT, 32'h0000_0001);
    wr(`OFF_RELOAD, 32'h0000_0004);
    wr(`OFF_STATUS, 32'h0000_0001);
    wr(`OFF_CTRL, ctl(1, MODE_COUNTER, 0, 1, 0));
    PIN.pulses(2);
    repeat (6) @(posedge aclk);
    rd(`OFF_COUNT, d);
    chk("edge count", 32'h0000_0003, d);
    PIN.pulses(2);
    repeat (6) @(posedge aclk);
    rd(`OFF_COUNT, d);
    chk("count reload", 32'h0000_0001, d);
    rd(`OFF_STATUS, d);
    chk("status", 32'h0000_0001, d);
    wr(`OFF_CTRL, ctl(1, MODE_RESERVED, 0, 0, 0));
    PIN.pulses(1);
    repeat (6) @(posedge aclk);
    rd(`OFF_COUNT, d);
    chk("stopped count", 32'h0000_0001, d);
    summarize();
  end

  initial begin
    repeat (100000) @(posedge aclk);
    tmo();
  end
endmodule
